// File: logic/ueh_flags_top.sv
// Endpoint handshake flags of a five-endpoint USB function: APB registers, token answers,
// control endpoint phase tracking and per-endpoint interrupt pulses.
// Assumes a serial engine that reports tokens and outcomes as one-cycle pulses on clk_sys.
//
// What this block does
// - Control endpoint sets in-done after read data, no-data status, write status.
// - Direction bit picks the status phase: 0 write/no data, 1 read.
// - With last and loaded set, send the packet first, then enter status.
// - Interrupt after control status phase; last-packet bit stays set.
// - Control stall request answers IN/OUT tokens with STALL, incl. no-data.
// - Endpoints 1-4 answer IN/OUT tokens with STALL while stall requested.
// - Loaded clears on host ACK; isochronous clears once data is sent.
// - Clearing loaded with in-done set interrupts when enabled.
// - Control loaded clear with last set and direction 0 completes status by DATA1 IN.
// - Ack ones clear stall-done, out-packet and in-done; not stored.
// - Control ack bit 2 clears setup-received; not stored.
// - Stall-done sets after a STALL handshake went out.
// - Out-packet sets on stored OUT data; OUT tokens NAKed while set.
// - Setting out-packet interrupts when the endpoint interrupt is enabled.
// - Out-packet serves bulk, isochronous and interrupt OUT endpoints.
// - Endpoints 1-4 set in-done on a successful IN transaction.
// - Reserved status and control bits read as zero.
// - Valid SETUP sets setup-received and clears the other status flags.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ueh_consts.svh"
module ueh_flags_top
   import ueh_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`UEH_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tokValid,
   input wire logic [1:0] tokKind,
   input wire logic [2:0] tokEp,
   output logic rspValid,
   output logic [2:0] rspCode,
   input wire logic evValid,
   input wire logic [2:0] evKind,
   input wire logic [2:0] evEp,
   input wire logic [4:0] epIso,
   input wire logic [4:0] epIrqEn,
   output logic [4:0] epIrq
);

   // ==========================================================
   // Register decode
   // Returns {hit, isCtrl, ep[2:0]} for a word index
   function automatic logic [4:0] decodeIdx(input logic [13:0] idx);
      logic [4:0] r;
      r = 5'h00;
      case (idx)
         `UEH_IDX_EP0_CTRL: r = 5'b11000;
         `UEH_IDX_EP1_CTRL: r = 5'b11001;
         `UEH_IDX_EP2_CTRL: r = 5'b11010;
         `UEH_IDX_EP3_CTRL: r = 5'b11011;
         `UEH_IDX_EP4_CTRL: r = 5'b11100;
         `UEH_IDX_EP0_STAT: r = 5'b10000;
         `UEH_IDX_EP1_STAT: r = 5'b10001;
         `UEH_IDX_EP2_STAT: r = 5'b10010;
         `UEH_IDX_EP3_STAT: r = 5'b10011;
         `UEH_IDX_EP4_STAT: r = 5'b10100;
         default: r = 5'h00;
      endcase
      return r;
   endfunction

   // One-hot endpoint select; numbers above four select nothing
   function automatic logic [4:0] epOneHot(input logic [2:0] ep);
      logic [4:0] r;
      r = 5'h00;
      case (ep)
         3'd0: r = 5'b00001;
         3'd1: r = 5'b00010;
         3'd2: r = 5'b00100;
         3'd3: r = 5'b01000;
         3'd4: r = 5'b10000;
         default: r = 5'h00;
      endcase
      return r;
   endfunction

   logic [4:0] dec;
   logic decHit, decCtrl;
   logic [2:0] decEp;
   logic apbWrite;
   logic [4:0] ctrlWr;

   assign dec = decodeIdx(paddr[`UEH_PADDR_W-1:2]);
   assign decHit = dec[4];
   assign decCtrl = dec[3];
   assign decEp = dec[2:0];
   // Status registers are read-only; a write to them is a mapped no-op
   assign apbWrite = psel && penable && pwrite && decHit && decCtrl;
   assign ctrlWr = apbWrite ? epOneHot(decEp) : 5'h00;

   // ==========================================================
   // Per-endpoint flag banks
   logic [4:0] setInDone, setOutPkt, setStallDone, clrLoaded;
   logic setSetup0;
   logic [4:0] inDone, outPkt, loaded, stallReq, lastPkt, xferDir;
   logic [7:0] statusByte [0:4];
   logic [7:0] ctrlByte [0:4];

   // Separate banks so traffic on one endpoint never touches another
   generate
      for (genvar e = 0; e < `UEH_NUM_EP; e++) begin : g_ep
         ueh_ep_flags #(.IS_CTRL(e == 0)) u_flags (
            .clk_sys(clk_sys),
            .srst(srst),
            .wrEn(ctrlWr[e]),
            .wrData(pwdata[7:0]),
            .setInDone(setInDone[e]),
            .setOutPkt(setOutPkt[e]),
            .setStallDone(setStallDone[e]),
            .setSetup((e == 0) ? setSetup0 : 1'b0),
            .clrLoaded(clrLoaded[e]),
            .statusByte(statusByte[e]),
            .ctrlByte(ctrlByte[e]),
            .inDone(inDone[e]),
            .outPkt(outPkt[e]),
            .loaded(loaded[e]),
            .stallReq(stallReq[e]),
            .lastPkt(lastPkt[e]),
            .xferDir(xferDir[e])
         );
      end
   endgenerate

   // ==========================================================
   // APB slave: read data latched in setup, answer in the first access cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= !decHit;
         if (!decHit || decEp > 3'd4) begin
            prdata <= 32'h0000_0000;
         end else if (decCtrl) begin
            prdata <= {24'h00_0000, ctrlByte[decEp]};
         end else begin
            prdata <= {24'h00_0000, statusByte[decEp]};
         end
      end
   end

   assign pready = psel && penable;

   // ==========================================================
   // Control endpoint phase
   ueh_phase_t phase_reg;
   logic zlpPending_reg;
   logic [4:0] evSel;
   logic evIn, evAck, evOut, evSetup, evStall;
   logic ctrlAck, ctrlStatusIn, ctrlStatusOut;

   assign evSel = evValid ? epOneHot(evEp) : 5'h00;
   assign evIn = evKind == UEH_EV_IN_SENT;
   assign evAck = evKind == UEH_EV_IN_ACKED;
   assign evOut = evKind == UEH_EV_OUT_STORED;
   assign evSetup = evKind == UEH_EV_SETUP_STORED;
   assign evStall = evKind == UEH_EV_STALL_SENT;

   assign ctrlAck = evSel[0] && evAck;
   // DATA1 zero-length IN acked: status after control write or no data stage
   assign ctrlStatusIn = ctrlAck && zlpPending_reg;
   // Zero-length OUT in status phase: status after a control read
   assign ctrlStatusOut = evSel[0] && evOut && phase_reg == UEH_PH_STATUS && xferDir[0];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         phase_reg <= UEH_PH_IDLE;
      end else if (evSel[0] && evSetup) begin
         phase_reg <= UEH_PH_DATA;
      end else begin
         case (phase_reg)
            UEH_PH_IDLE: phase_reg <= UEH_PH_IDLE;
            UEH_PH_DATA: begin
               // Waits until the last loaded packet is gone
               if (lastPkt[0] && !loaded[0]) phase_reg <= UEH_PH_STATUS;
            end
            UEH_PH_STATUS: begin
               if (ctrlStatusIn || ctrlStatusOut) phase_reg <= UEH_PH_IDLE;
            end
            default: phase_reg <= UEH_PH_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Token answers, one cycle after the token
   ueh_rsp_t rspNext;
   logic [4:0] tokSel;
   logic tokOnZlp;

   assign tokSel = epOneHot(tokEp);

   always_comb begin
      rspNext = UEH_RSP_NONE;
      tokOnZlp = 1'b0;
      if (tokSel != 5'h00) begin
         if (tokKind == UEH_TOK_SETUP) begin
            // A setup to endpoint 0 is always acked, even over unread OUT data; endpoints 1-4 get no answer
            rspNext = (tokSel[0]) ? UEH_RSP_ACK : UEH_RSP_NONE;
         end else if ((tokSel & stallReq) != 5'h00) begin
            // Also covers the status of a stalled no-data transfer
            rspNext = UEH_RSP_STALL;
         end else if (tokKind == UEH_TOK_OUT) begin
            rspNext = ((tokSel & outPkt) != 5'h00) ? UEH_RSP_NAK : UEH_RSP_ACK;
         end else if (tokKind == UEH_TOK_IN) begin
            if ((tokSel & loaded) != 5'h00) begin
               rspNext = UEH_RSP_DATA;
            end else if (tokSel[0] && phase_reg == UEH_PH_STATUS && !xferDir[0]) begin
               // Status stage direction from the direction bit
               rspNext = UEH_RSP_ZLP1;
               tokOnZlp = 1'b1;
            end else begin
               rspNext = UEH_RSP_NAK;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rspValid <= 1'b0;
         rspCode <= UEH_RSP_NONE;
      end else begin
         rspValid <= tokValid;
         rspCode <= tokValid ? rspNext : UEH_RSP_NONE;
      end
   end

   // Remembers that the answer in flight on the control endpoint is the status packet
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         zlpPending_reg <= 1'b0;
      end else if (evSel[0] && evSetup) begin
         zlpPending_reg <= 1'b0;
      end else if (tokValid && tokOnZlp) begin
         zlpPending_reg <= 1'b1;
      end else if (ctrlAck) begin
         zlpPending_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Outcome to flag strobes
   always_comb begin
      setInDone = 5'h00;
      setOutPkt = 5'h00;
      setStallDone = 5'h00;
      clrLoaded = 5'h00;
      setSetup0 = evSel[0] && evSetup;
      for (int e = 0; e < `UEH_NUM_EP; e++) begin
         if (evSel[e]) begin
            if (evStall) setStallDone[e] = 1'b1;
            if (evOut) setOutPkt[e] = 1'b1;
            // Isochronous data gets no handshake, so sending ends it
            if (evIn && epIso[e]) begin
               clrLoaded[e] = 1'b1;
               if (e != 0) setInDone[e] = 1'b1;
            end
            if (evAck && !epIso[e]) begin
               if (e != 0) begin
                  clrLoaded[e] = 1'b1;
                  setInDone[e] = 1'b1;
               end else if (zlpPending_reg) begin
                  setInDone[e] = 1'b1;
               end else begin
                  clrLoaded[e] = 1'b1;
                  // Last data packet acked ends a control read data stage
                  if (lastPkt[0]) setInDone[e] = 1'b1;
               end
            end
         end
      end
   end

   // ==========================================================
   // Interrupt pulses, gated by the endpoint's enable
   logic [4:0] irqCause;
   always_comb begin
      irqCause = setOutPkt;
      irqCause = irqCause | (clrLoaded & (inDone | setInDone));
      irqCause[0] = irqCause[0] | setSetup0;
      // Last-packet bit is left for firmware to clear
      irqCause[0] = irqCause[0] | ctrlStatusIn | ctrlStatusOut;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         epIrq <= 5'h00;
      end else begin
         epIrq <= irqCause & epIrqEn;
      end
   end

endmodule
`default_nettype wire

// File: logic/ueh_consts.svh
// Offsets, field positions, reset values and bus figures of the endpoint flag block.
// Assumes an APB master with 32-bit data; register indices are times four on the bus.
`ifndef UEH_CONSTS_SVH
`define UEH_CONSTS_SVH

// ==========================================================
// Register indices (byte address = index * 4)
`define UEH_IDX_EP3_CTRL 14'h1FA2
`define UEH_IDX_EP2_CTRL 14'h1FA3
`define UEH_IDX_EP1_CTRL 14'h1FA4
`define UEH_IDX_EP0_CTRL 14'h1FA5
`define UEH_IDX_EP4_CTRL 14'h1FA6
`define UEH_IDX_EP3_STAT 14'h1FDA
`define UEH_IDX_EP2_STAT 14'h1FDB
`define UEH_IDX_EP1_STAT 14'h1FDC
`define UEH_IDX_EP0_STAT 14'h1FDD
`define UEH_IDX_EP4_STAT 14'h1FDE

// ==========================================================
// Control and acknowledge fields
`define UEH_CTL_DIR 7
`define UEH_CTL_LAST 6
`define UEH_CTL_STALL 5
`define UEH_CTL_LOADED 4
`define UEH_ACK_STALL 3
`define UEH_ACK_SETUP 2
`define UEH_ACK_OUT 1
`define UEH_ACK_IN 0

// ==========================================================
// Status fields
`define UEH_ST_STALL 3
`define UEH_ST_SETUP 2
`define UEH_ST_OUT 1
`define UEH_ST_IN 0

// ==========================================================
// Reset values and sizes
`define UEH_CTRL_RESET 8'h00
`define UEH_STAT_RESET 8'h00
`define UEH_NUM_EP 5
`define UEH_PADDR_W 16

`endif

// File: logic/ueh_pkg.sv
// Types shared by the endpoint flag block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ueh_pkg;

   // ==========================================================
   // Token kinds from the serial engine
   typedef enum logic [1:0] {
      UEH_TOK_OUT = 2'b00,
      UEH_TOK_IN = 2'b01,
      UEH_TOK_SETUP = 2'b10
   } ueh_tok_t;

   // ==========================================================
   // Answers to a token
   typedef enum logic [2:0] {
      UEH_RSP_NONE = 3'b000,
      UEH_RSP_ACK = 3'b001,
      UEH_RSP_NAK = 3'b010,
      UEH_RSP_STALL = 3'b011,
      UEH_RSP_DATA = 3'b100,
      UEH_RSP_ZLP1 = 3'b101
   } ueh_rsp_t;

   // ==========================================================
   // Transaction outcomes reported by the serial engine
   typedef enum logic [2:0] {
      UEH_EV_IN_SENT = 3'b000,
      UEH_EV_IN_ACKED = 3'b001,
      UEH_EV_OUT_STORED = 3'b010,
      UEH_EV_SETUP_STORED = 3'b011,
      UEH_EV_STALL_SENT = 3'b100
   } ueh_ev_t;

   // ==========================================================
   // Control endpoint transfer phase
   typedef enum logic [1:0] {
      UEH_PH_IDLE = 2'b00,
      UEH_PH_DATA = 2'b01,
      UEH_PH_STATUS = 2'b10
   } ueh_phase_t;

endpackage
`default_nettype wire

// File: logic/ueh_ep_flags.sv
// One endpoint's status flags and control/acknowledge bits.
// Assumes set and clear strobes are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "ueh_consts.svh"
module ueh_ep_flags #(
   parameter bit IS_CTRL = 1'b0
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   input wire logic setInDone,
   input wire logic setOutPkt,
   input wire logic setStallDone,
   input wire logic setSetup,
   input wire logic clrLoaded,
   output logic [7:0] statusByte,
   output logic [7:0] ctrlByte,
   output logic inDone,
   output logic outPkt,
   output logic loaded,
   output logic stallReq,
   output logic lastPkt,
   output logic xferDir
);
   logic inDone_reg, outPkt_reg, stallDone_reg, setup_reg;
   logic dir_reg, last_reg, stall_reg, loaded_reg;

   // ==========================================================
   // Status flags: a hardware set beats a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         inDone_reg <= 1'b0;
         outPkt_reg <= 1'b0;
         stallDone_reg <= 1'b0;
         setup_reg <= 1'b0;
      end else begin
         // Ones clear, zeros leave alone, nothing is stored
         if (setInDone) inDone_reg <= 1'b1;
         else if (setSetup || (wrEn && wrData[`UEH_ACK_IN])) inDone_reg <= 1'b0;
         if (setOutPkt) outPkt_reg <= 1'b1;
         else if (setSetup || (wrEn && wrData[`UEH_ACK_OUT])) outPkt_reg <= 1'b0;
         if (setStallDone) stallDone_reg <= 1'b1;
         else if (setSetup || (wrEn && wrData[`UEH_ACK_STALL])) stallDone_reg <= 1'b0;
         if (IS_CTRL && setSetup) setup_reg <= 1'b1;
         else if (wrEn && wrData[`UEH_ACK_SETUP]) setup_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Control bits; a firmware load beats a hardware clear so a new packet is not lost
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dir_reg <= 1'b0;
         last_reg <= 1'b0;
         stall_reg <= 1'b0;
         loaded_reg <= 1'b0;
      end else if (wrEn) begin
         dir_reg <= IS_CTRL & wrData[`UEH_CTL_DIR];
         last_reg <= wrData[`UEH_CTL_LAST];
         stall_reg <= wrData[`UEH_CTL_STALL];
         loaded_reg <= wrData[`UEH_CTL_LOADED];
      end else if (clrLoaded) begin
         loaded_reg <= 1'b0;
      end
   end

   // Reserved bits read as zero
   assign statusByte = {4'h0, stallDone_reg, setup_reg & IS_CTRL, outPkt_reg, inDone_reg};
   assign ctrlByte = {dir_reg & IS_CTRL, last_reg, stall_reg, loaded_reg, 4'h0};
   assign inDone = inDone_reg;
   assign outPkt = outPkt_reg;
   assign loaded = loaded_reg;
   assign stallReq = stall_reg;
   assign lastPkt = last_reg;
   assign xferDir = dir_reg;
endmodule
`default_nettype wire

// File: verification/ueh_flags_asserts.sv
// Concurrent checks on the ports of the endpoint flag block.
// Assumes the bind below attaches it to every instance of the block's top module.
`timescale 1ns/1ps
`default_nettype none
`include "ueh_consts.svh"
module ueh_flags_asserts
   import ueh_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`UEH_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tokValid,
   input wire logic [1:0] tokKind,
   input wire logic [2:0] tokEp,
   input wire logic rspValid,
   input wire logic [2:0] rspCode,
   input wire logic evValid,
   input wire logic [2:0] evKind,
   input wire logic [2:0] evEp,
   input wire logic [4:0] epIso,
   input wire logic [4:0] epIrqEn,
   input wire logic [4:0] epIrq
);
   // ==========================================================
   // Address decode
   logic [13:0] idx;
   logic mapped;
   logic isCtl;
   logic isSt;
   assign idx = paddr[15:2];
   assign isCtl = idx >= `UEH_IDX_EP3_CTRL && idx <= `UEH_IDX_EP4_CTRL;
   assign isSt = idx >= `UEH_IDX_EP3_STAT && idx <= `UEH_IDX_EP4_STAT;
   assign mapped = isCtl || isSt;

   // ==========================================================
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_acc(m);
      psel && penable && mapped == m;
   endsequence
   sequence s_setup0;
      tokValid && tokKind == UEH_TOK_SETUP && tokEp == 3'd0;
   endsequence

   a_ready_zero_wait: assert property (pready == (psel && penable))
      else $error("pready not in first access cycle");
   a_unmapped_err: assert property (s_acc(1'b0) |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (s_acc(1'b1) |-> !pslverr && prdata[31:8] == 24'h000000)
      else $error("mapped access refused or upper bits set");
   a_reserved_zero: assert property (s_acc(1'b1) ##0 !pwrite && idx != `UEH_IDX_EP0_STAT
      && idx != `UEH_IDX_EP0_CTRL |-> !prdata[2] && (isCtl ? !prdata[7] : prdata[7:4] == 4'h0))
      else $error("reserved bit reads one");
   a_rsp_follows: assert property (tokValid |=> rspValid)
      else $error("token not answered next cycle");
   a_rsp_cause: assert property (rspValid |-> $past(tokValid))
      else $error("answer without token");
   a_bad_ep_none: assert property (tokValid && tokEp > 3'd4 |=> rspCode == UEH_RSP_NONE)
      else $error("answer for missing endpoint");
   a_setup_ack: assert property (s_setup0 |=> rspCode == UEH_RSP_ACK)
      else $error("setup not acknowledged");
   a_out_irq: assert property (evValid && evKind == UEH_EV_OUT_STORED && evEp < 3'd5
      && epIrqEn[evEp] |=> epIrq[$past(evEp)])
      else $error("out packet interrupt missing");
   a_irq_cause: assert property (epIrq != 5'h00 |-> $past(evValid)
      && epIrq == ((5'h01 << $past(evEp)) & $past(epIrqEn)))
      else $error("interrupt on wrong endpoint or masked");
endmodule

bind ueh_flags_top ueh_flags_asserts i_ueh_flags_asserts (.clk_sys(clk_sys), .srst(srst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .tokValid(tokValid),
   .tokKind(tokKind), .tokEp(tokEp), .rspValid(rspValid), .rspCode(rspCode),
   .evValid(evValid), .evKind(evKind), .evEp(evEp), .epIso(epIso), .epIrqEn(epIrqEn),
   .epIrq(epIrq));
`default_nettype wire

// File: verification/ueh_host_model.sv
// Host and serial engine model: sends tokens and reports transaction outcomes.
// Assumes tasks are called from the bench just after a rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ueh_host_model
   import ueh_pkg::*;
(
   input wire logic clk_sys,
   output logic tokValid,
   output logic [1:0] tokKind,
   output logic [2:0] tokEp,
   output logic evValid,
   output logic [2:0] evKind,
   output logic [2:0] evEp,
   input wire logic rspValid,
   input wire logic [2:0] rspCode
);
   // ==========================================================
   // Idle cycles before each request; a slow host sets it above zero
   int gap = 0;
   initial begin
      tokValid = 1'b0;
      tokKind = 2'b00;
      tokEp = 3'd0;
      evValid = 1'b0;
      evKind = 3'd0;
      evEp = 3'd0;
   end
   // Fields are inverted once released so stale values never repeat the last request
   task automatic send_tok(input ueh_tok_t k, input logic [2:0] e, output logic [2:0] r);
      repeat (gap) @(posedge clk_sys);
      @(posedge clk_sys);
      tokValid <= 1'b1;
      tokKind <= k;
      tokEp <= e;
      @(posedge clk_sys);
      tokValid <= 1'b0;
      tokKind <= ~k;
      tokEp <= ~e;
      #1;
      r = rspValid ? rspCode : 3'h7;
   endtask
   task automatic send_ev(input ueh_ev_t k, input logic [2:0] e);
      repeat (gap) @(posedge clk_sys);
      @(posedge clk_sys);
      evValid <= 1'b1;
      evKind <= k;
      evEp <= e;
      @(posedge clk_sys);
      evValid <= 1'b0;
      evKind <= ~k;
      evEp <= ~e;
      #1;
   endtask
endmodule
`default_nettype wire

// File: verification/ueh_flags_top_tb.sv
// Self-checking bench of the endpoint flag block; the bench plays the firmware on APB.
// Assumes the host model drives the token and outcome ports.
`timescale 1ns/1ps
`default_nettype none
`include "ueh_consts.svh"
module ueh_flags_top_tb
   import ueh_pkg::*;
();
   // ==========================================================
   // Signals
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rdv;
   logic pready, pslverr, tokValid, rspValid, evValid, errv;
   logic [1:0] tokKind;
   logic [2:0] tokEp, rspCode, evKind, evEp, rsp;
   logic [4:0] epIso = 5'h00;
   logic [4:0] epIrqEn = 5'h1F;
   logic [4:0] epIrq;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   localparam logic [13:0] CI [5] = '{`UEH_IDX_EP0_CTRL, `UEH_IDX_EP1_CTRL,
      `UEH_IDX_EP2_CTRL, `UEH_IDX_EP3_CTRL, `UEH_IDX_EP4_CTRL};
   localparam logic [13:0] SI [5] = '{`UEH_IDX_EP0_STAT, `UEH_IDX_EP1_STAT,
      `UEH_IDX_EP2_STAT, `UEH_IDX_EP3_STAT, `UEH_IDX_EP4_STAT};

   always #10 clk_sys = ~clk_sys;
   ueh_flags_top i_ueh_flags_top (.clk_sys(clk_sys), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tokValid(tokValid), .tokKind(tokKind),
      .tokEp(tokEp), .rspValid(rspValid), .rspCode(rspCode), .evValid(evValid),
      .evKind(evKind), .evEp(evEp), .epIso(epIso), .epIrqEn(epIrqEn), .epIrq(epIrq));
   ueh_host_model i_ueh_host_model (.clk_sys(clk_sys), .tokValid(tokValid),
      .tokKind(tokKind), .tokEp(tokEp), .evValid(evValid), .evKind(evKind), .evEp(evEp),
      .rspValid(rspValid), .rspCode(rspCode));

   // ==========================================================
   // Shared tasks
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Master waits for pready with no assumed latency
   task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [13:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rdv | {errv, 31'h0}, {24'h000000, exp});
   endtask
   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic tk(input ueh_tok_t k, input logic [2:0] e, input ueh_rsp_t exp);
      i_ueh_host_model.send_tok(k, e, rsp);
      chk(rsp, exp);
   endtask
   task automatic evt(input ueh_ev_t k, input logic [2:0] e, input logic [4:0] irq);
      i_ueh_host_model.send_ev(k, e);
      chk(epIrq, irq);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs();
      for (int i = 0; i < 5; i++) begin
         rd(CI[i], 8'h00);
         rd(SI[i], 8'h00);
      end
      apb(1'b0, 14'h1FA7, 8'h00);
      chk({errv, rdv[30:0]}, 32'h8000_0000);
      wr(SI[1], 8'hFF);
      rd(SI[1], 8'h00);
   endtask
   task automatic t_out();
      evt(UEH_EV_OUT_STORED, 3'd2, 5'h04);
      rd(SI[2], 8'h02);
      rd(SI[1], 8'h00);
      tk(UEH_TOK_OUT, 3'd2, UEH_RSP_NAK);
      wr(CI[2], 8'h02);
      rd(SI[2], 8'h00);
      rd(CI[2], 8'h00);
      tk(UEH_TOK_OUT, 3'd2, UEH_RSP_ACK);
      tk(UEH_TOK_SETUP, 3'd2, UEH_RSP_NONE);
      tk(UEH_TOK_IN, 3'd5, UEH_RSP_NONE);
   endtask
   task automatic t_in();
      wr(CI[1], 8'h10);
      tk(UEH_TOK_IN, 3'd1, UEH_RSP_DATA);
      evt(UEH_EV_IN_ACKED, 3'd1, 5'h02);
      rd(CI[1], 8'h00);
      rd(SI[1], 8'h01);
      tk(UEH_TOK_IN, 3'd1, UEH_RSP_NAK);
      wr(CI[1], 8'h01);
      rd(SI[1], 8'h00);
      epIrqEn <= 5'h17;
      epIso <= 5'h08;
      wr(CI[3], 8'h10);
      evt(UEH_EV_IN_SENT, 3'd3, 5'h00);
      rd(CI[3], 8'h00);
      rd(SI[3], 8'h01);
      wr(CI[3], 8'h01);
      epIrqEn <= 5'h1F;
      epIso <= 5'h00;
   endtask
   task automatic t_stall();
      wr(CI[4], 8'hA4);
      rd(CI[4], 8'h20);
      tk(UEH_TOK_IN, 3'd4, UEH_RSP_STALL);
      tk(UEH_TOK_OUT, 3'd4, UEH_RSP_STALL);
      evt(UEH_EV_STALL_SENT, 3'd4, 5'h00);
      rd(SI[4], 8'h08);
      wr(CI[4], 8'h28);
      rd(SI[4], 8'h00);
      rd(CI[4], 8'h20);
      wr(CI[4], 8'h00);
   endtask
   task automatic t_ctl_read();
      i_ueh_host_model.gap = 2;
      evt(UEH_EV_STALL_SENT, 3'd0, 5'h00);
      tk(UEH_TOK_SETUP, 3'd0, UEH_RSP_ACK);
      evt(UEH_EV_SETUP_STORED, 3'd0, 5'h01);
      rd(SI[0], 8'h04);
      wr(CI[0], 8'h04);
      rd(SI[0], 8'h00);
      wr(CI[0], 8'hD0);
      tk(UEH_TOK_IN, 3'd0, UEH_RSP_DATA);
      evt(UEH_EV_IN_ACKED, 3'd0, 5'h01);
      rd(SI[0], 8'h01);
      tk(UEH_TOK_OUT, 3'd0, UEH_RSP_ACK);
      evt(UEH_EV_OUT_STORED, 3'd0, 5'h01);
      rd(CI[0], 8'hC0);
      rd(SI[0], 8'h03);
      wr(CI[0], 8'h03);
      wr(CI[0], 8'h00);
      i_ueh_host_model.gap = 0;
   endtask
   task automatic t_ctl_nodata();
      evt(UEH_EV_SETUP_STORED, 3'd0, 5'h01);
      wr(CI[0], 8'h44);
      tk(UEH_TOK_IN, 3'd0, UEH_RSP_ZLP1);
      evt(UEH_EV_IN_ACKED, 3'd0, 5'h01);
      rd(SI[0], 8'h01);
      wr(CI[0], 8'h21);
      tk(UEH_TOK_OUT, 3'd0, UEH_RSP_STALL);
      tk(UEH_TOK_IN, 3'd0, UEH_RSP_STALL);
      rd(SI[0], 8'h00);
      wr(CI[0], 8'h00);
   endtask

   // ==========================================================
   // Sequence and hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         $display("Error %0t: run took too long", $time);
         end_of_test();
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      t_regs();
      t_out();
      t_in();
      t_stall();
      t_ctl_read();
      t_ctl_nodata();
      end_of_test();
   end
endmodule
`default_nettype wire
